// ==== design/relay_ctrl_defines.svh ====
// Constants for the four-bit identification relay controller
// Behaviour
// - Poll up to four heads, treat alike
// - Outputs never show which head read
// - Each set carrier bit activates its relay
// - Several set bits activate relays together
// - All-zero carrier activates nothing
// - Hold time ends output despite carrier presence
// - Hold time spans 0.02 to 5.1 s
// - Hold parameter 01..FF times 20 ms
// - Hold command letters, parameter, CR LF; silent
// - Hold value 00 latches outputs on
// - Latched output cleared only by clear or restart command
// - Bits from two bytes, high nibble inverted
// - Byte 0 bit n drives relay n+1
// - Mode when switches a,b closed, c open
// - Re-set during hold restarts hold time
// - New hold value applies at next setting
// - Hold value kept across power cycles
// - Outputs inactive at power-on and restart
`ifndef RELAY_CTRL_DEFINES_SVH
`define RELAY_CTRL_DEFINES_SVH
`define CLK_HZ 20000000
`define TICK_MS 20
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define HOLD_RST 8'h00
`define NHEADS 4
`endif

// ==== design/relay_ctrl_pkg.sv ====
// Types for the four-bit identification relay controller
package relay_ctrl_pkg;
  typedef struct packed {
    logic [7:0] byte1;
    logic [7:0] byte0;
  } carrier_s;
  typedef enum logic [1:0] {
    HEAD_0 = 2'b00,
    HEAD_1 = 2'b01,
    HEAD_2 = 2'b10,
    HEAD_3 = 2'b11
  } head_e;
endpackage

// ==== design/four_bit_ident_relay_ctrl.sv ====
// Four-bit identification relay output controller
`timescale 1ns/1ns
`include "relay_ctrl_defines.svh"
module four_bit_ident_relay_ctrl #(
  // Clocks per hold tick; a bench may shorten it, must not exceed 2**20
  parameter int unsigned TICK_N = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Mode switches, closed = 1
  input wire logic mode_switch_a_in,
  input wire logic mode_switch_b_in,
  input wire logic mode_switch_c_in,
  // Read heads: one read-done strobe and carrier data per head
  input wire logic [3:0] head_read_valid_in,
  input wire relay_ctrl_pkg::carrier_s head_data_in [4],
  // Decoded serial commands, one-cycle strobes
  input wire logic hold_time_cmd_in,
  input wire logic [7:0] hold_time_value_in,
  input wire logic output_clear_cmd_in,
  input wire logic [3:0] output_clear_mask_in,
  input wire logic restart_cmd_in,
  // Hold value restored from non-volatile store
  input wire logic nv_load_in,
  input wire logic [7:0] nv_hold_in,
  // Head poll select and non-volatile write-back
  output logic [1:0] head_sel_out,
  output logic nv_write_out,
  output logic [7:0] nv_wdata_out,
  // Relay outputs
  output logic relay_out_1,
  output logic relay_out_2,
  output logic relay_out_3,
  output logic relay_out_4
);
  logic [19:0] tick_cnt_q;
  logic tick;
  logic [1:0] head_q;
  logic [7:0] hold_q;
  logic [7:0] cnt_q [4];
  logic [3:0] relay_q;
  logic nv_write_q;
  logic [7:0] nv_wdata_q;
  wire mode_ok = mode_switch_a_in & mode_switch_b_in & ~mode_switch_c_in;
  // Poll heads round-robin; a read on the polled head is taken
  wire relay_ctrl_pkg::carrier_s cur = head_data_in[head_q];
  wire cur_valid = head_read_valid_in[head_q] & mode_ok;
  wire [3:0] d0 = cur.byte0[3:0];
  wire good = (cur.byte0[7:4] == ~d0) && (cur.byte0 == cur.byte1);
  wire [3:0] set_mask = (cur_valid && good) ? d0 : 4'h0;
  wire clr_mask_v = output_clear_cmd_in;
  assign tick = (tick_cnt_q == 20'(TICK_N - 1));
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || tick) begin
      tick_cnt_q <= 20'h0_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 20'h0_0001;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      head_q <= 2'h0;
    end else begin
      head_q <= head_q + 2'h1;
    end
  end
  // Hold value; new value affects only later settings since counters load at set
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      hold_q <= `HOLD_RST;
      nv_write_q <= 1'b0;
      nv_wdata_q <= 8'h00;
    end else begin
      nv_write_q <= hold_time_cmd_in;
      if (hold_time_cmd_in) begin
        hold_q <= hold_time_value_in;
        nv_wdata_q <= hold_time_value_in;
      end else if (nv_load_in) begin
        hold_q <= nv_hold_in;
      end
    end
  end
  genvar i;
  for (i = 0; i < 4; i++) begin : g_out
    always_ff @(posedge mclk_in) begin
      if (sys_rst_in || restart_cmd_in) begin
        relay_q[i] <= 1'b0;
        cnt_q[i] <= 8'h00;
      end else if (set_mask[i]) begin
        relay_q[i] <= 1'b1;
        cnt_q[i] <= hold_q;
      end else if (clr_mask_v && output_clear_mask_in[i]) begin
        relay_q[i] <= 1'b0;
        cnt_q[i] <= 8'h00;
      end else if (tick && relay_q[i] && cnt_q[i] != 8'h00) begin
        cnt_q[i] <= cnt_q[i] - 8'h01;
        if (cnt_q[i] == 8'h01) begin
          relay_q[i] <= 1'b0;
        end
      end
    end
  end
  assign head_sel_out = head_q;
  assign nv_write_out = nv_write_q;
  assign nv_wdata_out = nv_wdata_q;
  assign relay_out_1 = relay_q[0];
  assign relay_out_2 = relay_q[1];
  assign relay_out_3 = relay_q[2];
  assign relay_out_4 = relay_q[3];

  // Checks
  latch_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (set_mask[0] && hold_q == 8'h00 && !restart_cmd_in) |=> (relay_out_1 && cnt_q[0] == 8'h00))
    else $error("latched set failed");
  set_on_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (set_mask[1] && !restart_cmd_in) |=> relay_out_2)
    else $error("relay not set");
  bad_ignore_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!good && !output_clear_cmd_in && !restart_cmd_in && !tick) |=> $stable(relay_q))
    else $error("bad carrier changed relays");
  mode_gate_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !mode_ok |-> set_mask == 4'h0)
    else $error("set outside mode");
  clear_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (output_clear_cmd_in && output_clear_mask_in[2] && !set_mask[2]) |=> !relay_out_3)
    else $error("clear failed");
  restart_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    restart_cmd_in |=> relay_q == 4'h0)
    else $error("restart left relay on");
  expire_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (tick && relay_q[3] && cnt_q[3] == 8'h01 && !set_mask[3] && !restart_cmd_in)
    |=> !relay_out_4)
    else $error("hold expiry failed");
  hold_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    hold_time_cmd_in |=> (hold_q == $past(hold_time_value_in) && nv_write_out))
    else $error("hold value not stored");
  tick_period_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    tick |=> !tick)
    else $error("tick too frequent");
  // Helpers for the checks below
  wire [3:0] clr_hit = clr_mask_v ? output_clear_mask_in : 4'h0;
  wire expire_2 = tick && (cnt_q[1] == 8'h01);
  // Reset and polling
  reset_idle_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> (relay_q == 4'h0 && head_sel_out == 2'h0 && !nv_write_out))
    else $error("reset left outputs active");
  head_step_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) |-> (head_sel_out == $past(head_sel_out) + 2'h1))
    else $error("head poll skipped");
  // Carrier decode: the pattern comes only from the carrier bytes
  head_blind_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cur_valid && good) |-> (set_mask == cur.byte1[3:0]))
    else $error("set pattern not from carrier");
  invert_reject_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cur_valid && (cur.byte1[7:4] != ~cur.byte1[3:0])) |-> (set_mask == 4'h0))
    else $error("uninverted carrier accepted");
  pair_reject_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cur_valid && (cur.byte0 != cur.byte1)) |-> (set_mask == 4'h0))
    else $error("mismatched carrier bytes accepted");
  set_first_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cur_valid && good && cur.byte0[0] && !restart_cmd_in) |=> relay_out_1)
    else $error("bit 0 did not set relay 1");
  set_four_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cur_valid && good && cur.byte0[3] && !restart_cmd_in) |=> relay_out_4)
    else $error("bit 3 did not set relay 4");
  set_all_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (set_mask != 4'h0 && !restart_cmd_in)
    |=> ((relay_q & $past(set_mask)) == $past(set_mask)))
    else $error("not all matching relays set");
  zero_ignore_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cur_valid && good && d0 == 4'h0 && !output_clear_cmd_in && !restart_cmd_in && !tick)
    |=> $stable(relay_q))
    else $error("zero carrier changed relays");
  mode_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!mode_ok && !output_clear_cmd_in && !restart_cmd_in && !tick)
    |=> $stable(relay_q))
    else $error("relays changed outside mode");
  // Hold timing, shown on relay 2
  count_down_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (tick && relay_q[1] && cnt_q[1] > 8'h01 && !set_mask[1] && !restart_cmd_in
      && !clr_hit[1])
    |=> (relay_out_2 && cnt_q[1] == $past(cnt_q[1]) - 8'h01))
    else $error("hold count did not step");
  expire_two_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (expire_2 && relay_q[1] && !set_mask[1] && !restart_cmd_in && !clr_hit[1])
    |=> (!relay_out_2 && cnt_q[1] == 8'h00))
    else $error("relay 2 outlived its hold");
  retrig_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (set_mask[1] && !restart_cmd_in) |=> (cnt_q[1] == $past(hold_q)))
    else $error("hold not restarted on set");
  hold_keep_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hold_time_cmd_in && !tick && !set_mask[1] && !restart_cmd_in && !clr_hit[1])
    |=> (cnt_q[1] == $past(cnt_q[1])))
    else $error("new hold value hit running count");
  latch_stay_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (relay_q[1] && cnt_q[1] == 8'h00 && !restart_cmd_in && !clr_hit[1])
    |=> relay_out_2)
    else $error("latched relay dropped");
  // Relays drop only by clear, restart or hold expiry
  off_cause_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!$past(sys_rst_in) && $fell(relay_out_2))
    |-> ($past(restart_cmd_in) || $past(clr_hit[1]) || $past(expire_2)))
    else $error("relay 2 dropped without cause");
  clear_keep_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!output_clear_cmd_in && !restart_cmd_in && !tick)
    |=> ((relay_q | ~$past(relay_q)) == 4'hF))
    else $error("relay dropped without clear");
  clear_all_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (output_clear_cmd_in && !restart_cmd_in)
    |=> ((relay_q & $past(clr_hit) & ~$past(set_mask)) == 4'h0))
    else $error("masked relay not cleared");
  // Hold value storage
  nv_data_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    hold_time_cmd_in |=> (nv_wdata_out == $past(hold_time_value_in)))
    else $error("store data wrong");
  nv_quiet_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !hold_time_cmd_in |=> !nv_write_out)
    else $error("store write without command");
  nv_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (nv_load_in && !hold_time_cmd_in) |=> (hold_q == $past(nv_hold_in)))
    else $error("restored hold value lost");
  hold_stable_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!hold_time_cmd_in && !nv_load_in) |=> $stable(hold_q))
    else $error("hold value changed by itself");
  multi_c: cover property (@(posedge mclk_in) set_mask == 4'hF);
  expire_c: cover property (@(posedge mclk_in) $fell(relay_out_1));
  clear_c: cover property (@(posedge mclk_in) output_clear_cmd_in && relay_q != 4'h0);
  retrig_c: cover property (@(posedge mclk_in)
    set_mask[1] && relay_q[1] && cnt_q[1] != 8'h00);
  latch_c: cover property (@(posedge mclk_in)
    set_mask[1] && hold_q == 8'h00);
endmodule // four_bit_ident_relay_ctrl

// ==== verification/head_model.sv ====
// Read head model presenting one carrier to the armed heads
`timescale 1ns/1ns
module head_model (
  // Stimulus
  input wire logic [3:0] arm_in,
  input wire relay_ctrl_pkg::carrier_s carrier_in,
  // Head side
  output logic [3:0] valid_out,
  output relay_ctrl_pkg::carrier_s data_out [4]
);
  // Idle heads show inverted data, never a stale copy
  always_comb begin
    valid_out = arm_in;
    for (int i = 0; i < 4; i++) begin
      data_out[i] = arm_in[i] ? carrier_in : ~carrier_in;
    end
  end
endmodule // head_model

// ==== verification/tb.sv ====
// Testbench for the relay output controller
`timescale 1ns/1ns
module tb;
  logic mclk_in = 0, sys_rst_in = 1, ma = 1, mb = 1, mc = 0, hc = 0, cc = 0, rc = 0;
  logic [3:0] arm = 4'h0, cm = 4'h0, hv_ok, rel;
  logic [7:0] hv = 8'h00, wd, nh = 8'h00;
  logic [1:0] hs;
  logic r1, r2, r3, r4, nw, nl = 0;
  relay_ctrl_pkg::carrier_s car = 16'h0000;
  relay_ctrl_pkg::carrier_s hd [4];
  int bad_count = 0, total_checks = 0, cyc = 0;
  assign rel = {r4, r3, r2, r1};
  head_model i_head_model (.arm_in(arm), .carrier_in(car), .valid_out(hv_ok), .data_out(hd));
  four_bit_ident_relay_ctrl #(.TICK_N(40)) i_four_bit_ident_relay_ctrl (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .mode_switch_a_in(ma), .mode_switch_b_in(mb),
    .mode_switch_c_in(mc), .head_read_valid_in(hv_ok), .head_data_in(hd),
    .hold_time_cmd_in(hc), .hold_time_value_in(hv), .output_clear_cmd_in(cc),
    .output_clear_mask_in(cm), .restart_cmd_in(rc), .nv_load_in(nl),
    .nv_hold_in(nh), .head_sel_out(hs), .nv_write_out(nw), .nv_wdata_out(wd),
    .relay_out_1(r1), .relay_out_2(r2), .relay_out_3(r3), .relay_out_4(r4));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  task step(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // Armed for five cycles so every polled slot passes by
  task rd(logic [15:0] v, logic [3:0] h);
    car = v;
    arm = h;
    step(5);
    arm = 4'h0;
    step(2);
  endtask
  // Host line framing is decoded upstream; one strobe per command
  task send_hold(logic [7:0] v);
    hc = 1;
    hv = v;
    step(1);
    hc = 0;
  endtask
  task finish_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 2000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    step(16);
    chk("head_sel", 8'h00, {6'h00, hs});
    chk("relays", 8'h00, {4'h0, rel});
    sys_rst_in = 0;
    step(1);
    chk("head_sel", 8'h01, {6'h00, hs});
    chk("relays", 8'h00, {4'h0, rel});
    rd(16'h7878, 4'h1);
    chk("relays", 8'h08, {4'h0, rel});
    rd(16'hA5A5, 4'h8);
    chk("relays", 8'h0D, {4'h0, rel});
    cc = 1;
    cm = 4'h1;
    step(1);
    cc = 0;
    step(1);
    chk("relays", 8'h0C, {4'h0, rel});
    rd(16'hF0F0, 4'h2);
    chk("relays", 8'h0C, {4'h0, rel});
    rd(16'h7B7B, 4'h2);
    chk("relays", 8'h0C, {4'h0, rel});
    rd(16'h7887, 4'h4);
    chk("relays", 8'h0C, {4'h0, rel});
    mc = 1;
    rd(16'hE1E1, 4'h4);
    chk("relays", 8'h0C, {4'h0, rel});
    mc = 0;
    rd(16'hE1E1, 4'h4);
    chk("relays", 8'h0D, {4'h0, rel});
    send_hold(8'h15);
    chk("nv_write", 8'h01, {7'h00, nw});
    chk("nv_wdata", 8'h15, wd);
    step(1);
    chk("nv_write", 8'h00, {7'h00, nw});
    // Restored hold of three ticks; expiry lands 81 to 120 cycles after a set
    nl = 1;
    nh = 8'h03;
    step(1);
    nl = 0;
    rd(16'hD2D2, 4'h2);
    chk("relays", 8'h0F, {4'h0, rel});
    step(50);
    rd(16'hD2D2, 4'h2);
    step(70);
    chk("relays", 8'h0F, {4'h0, rel});
    send_hold(8'h00);
    step(59);
    chk("relays", 8'h0D, {4'h0, rel});
    rd(16'hD2D2, 4'h2);
    step(200);
    chk("relays", 8'h0F, {4'h0, rel});
    rc = 1;
    step(1);
    rc = 0;
    chk("relays", 8'h00, {4'h0, rel});
    finish_test;
  end
endmodule // tb
